// File: rtl/ebct_top.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps

// Summary of operation
// - 8-bit up-counter advanced by the chosen clock, readable and writable anytime.
// - Wrap from all ones to zero sets the wrap flag.
// - Counter forced to zero on reset and in low-power modes.
// - Compare runs continuously except during a write cycle to that compare register.
// - Counter equal compare A sets match A flag; interrupt if enabled.
// - Compare B works the same with its own flag and enable.
// - Both compare registers reset to all ones, also in low-power modes.
// - Control register 0 resets to zero, also in low-power modes.
// - Control 0 bit 7 enables the match B interrupt.
// - Control 0 bit 6 enables the match A interrupt.
// - Control 0 bit 5 enables the wrap interrupt.
// - Clear select: none, match A, match B, external clear rising edge.
// - With clear selected and trigger enabled, clearing halts until a trigger edge.
// - With trigger disabled, counting continues right after a clear.
// - Internal clock codes 1..3 pick divide 4/8, 16/32, 64/128 by pair bit.
// - Clock codes 0 and 4 stop counting; 0 is the reset value.
// - Codes 5, 6, 7 count external clock rising, falling, both edges.
// - Internal divided clocks advance the counter on their falling edge.
// - Waveform pin changes on matches as the output-select bits say.
// - Trigger pin starts counting on rising, falling or both edges.
// - Setting trigger enable stops the counter until the chosen trigger edge.
// - Flags set by hardware only; cleared by writing 0 after reading 1.
// - Per-match output select: keep, drive 0, drive 1, toggle.
// - Simultaneous matches: toggle beats drive 1, drive 1 beats drive 0.
module ebct_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ebct_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        ext_count_clock_pin,
  input  wire logic                        ext_clear_pin,
  input  wire logic                        start_trigger_pin,
  input  wire logic                        low_power_mode,
  output logic                             wave_out_pin,
  output logic                             match_a_irq,
  output logic                             match_b_irq,
  output logic                             wrap_irq
);
  import ebct_pkg::*;

  ebct_state_s      s_r;
  ebct_state_s      s_nxt;
  logic [15:0]      idx;
  logic             aligned;
  logic             sel_ctl0;
  logic             sel_stat;
  logic             sel_cmpa;
  logic             sel_cmpb;
  logic             sel_cnt;
  logic             sel_ctl1;
  logic             mapped;
  logic             acc_wr;
  logic             acc_rd;
  logic             setup_rd;
  logic [7:0]       rd_mux;
  logic [7:0]       stat_view;
  logic [7:0]       ctl1_view;
  logic [PRE_W-1:0] pre_inc;
  logic [2:0]       tap;
  logic             int_fall;
  logic [NSYNC-1:0] rise;
  logic [NSYNC-1:0] fall;
  logic             tick;
  logic             match_a;
  logic             match_b;
  logic             do_clear;
  logic             trig;
  logic [1:0]       clr_sel;
  logic [2:0]       cks;
  logic [1:0]       act_a;
  logic [1:0]       act_b;
  logic [2:0]       flg_set;
  logic [2:0]       flg_wclr;
  logic [7:0]       wb;

  // Address decode; unaligned or unknown addresses answer with an error
  always_comb begin
    idx      = paddr[ADDR_W-1:2];
    aligned  = (paddr[1:0] == 2'h0);
    sel_ctl0 = aligned && (idx == IDX_CTL0);
    sel_stat = aligned && (idx == IDX_STAT);
    sel_cmpa = aligned && (idx == IDX_CMPA);
    sel_cmpb = aligned && (idx == IDX_CMPB);
    sel_cnt  = aligned && (idx == IDX_CNT);
    sel_ctl1 = aligned && (idx == IDX_CTL1);
    mapped   = sel_ctl0 | sel_stat | sel_cmpa | sel_cmpb | sel_cnt | sel_ctl1;
    acc_wr   = psel && penable && pwrite && mapped;
    acc_rd   = psel && penable && !pwrite && mapped;
    setup_rd = psel && !penable && !pwrite;
    wb       = pwdata[7:0];
  end

  // Zero-wait slave: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = s_r.rdata;

  // Register views with reserved bits reading as one
  always_comb begin
    stat_view = ST_FIXED;
    stat_view[ST_FLG_B] = s_r.flg[FL_B];
    stat_view[ST_FLG_A] = s_r.flg[FL_A];
    stat_view[ST_FLG_W] = s_r.flg[FL_W];
    stat_view[ST_OS_HI:0] = s_r.os;
    ctl1_view = C1_FIXED;
    ctl1_view[C1_EDG_HI:C1_EDG_LO] = s_r.edg;
    ctl1_view[C1_TE]  = s_r.te;
    ctl1_view[C1_DPS] = s_r.dps;
    rd_mux = 8'h00;
    if (sel_ctl0) begin
      rd_mux = s_r.ctl0;
    end
    if (sel_stat) begin
      rd_mux = stat_view;
    end
    if (sel_cmpa) begin
      rd_mux = s_r.cmpa;
    end
    if (sel_cmpb) begin
      rd_mux = s_r.cmpb;
    end
    if (sel_cnt) begin
      rd_mux = s_r.cnt;
    end
    if (sel_ctl1) begin
      rd_mux = ctl1_view;
    end
  end

  // Interrupt requests are gated flags
  assign match_b_irq  = s_r.flg[FL_B] & s_r.ctl0[C0_IE_B];
  assign match_a_irq  = s_r.flg[FL_A] & s_r.ctl0[C0_IE_A];
  assign wrap_irq     = s_r.flg[FL_W] & s_r.ctl0[C0_IE_W];
  assign wave_out_pin = s_r.wave;

  // Edge detection looks only at the second and third stages
  always_comb begin
    rise = s_r.sy2 & ~s_r.sy3;
    fall = ~s_r.sy2 & s_r.sy3;
  end

  // Counter clock source; a tap falls when the prescaler carries out of it
  always_comb begin
    cks      = s_r.ctl0[C0_CKS_HI:0];
    clr_sel  = s_r.ctl0[C0_CLR_HI:C0_CLR_LO];
    pre_inc  = s_r.pre + 7'h01;
    tap      = {cks[1:0], 1'b0} + {2'h0, s_r.dps} - 3'h1;
    int_fall = s_r.pre[tap] & ~pre_inc[tap];
    case (cks)
      CKS_D4, CKS_D16, CKS_D64: tick = int_fall;
      CKS_XR:  tick = rise[SY_CLK];
      CKS_XF:  tick = fall[SY_CLK];
      CKS_XB:  tick = rise[SY_CLK] | fall[SY_CLK];
      default: tick = 1'b0;
    endcase
  end

  // Compare is blanked during the access phase of a write to that register
  always_comb begin
    match_a  = (s_r.cnt == s_r.cmpa) && !(acc_wr && sel_cmpa) && !s_r.eqa;
    match_b  = (s_r.cnt == s_r.cmpb) && !(acc_wr && sel_cmpb) && !s_r.eqb;
    do_clear = ((clr_sel == CLR_A) && match_a) || ((clr_sel == CLR_B) && match_b)
             || ((clr_sel == CLR_EXT) && rise[SY_CLR]);
    trig     = s_r.te && ((rise[SY_TRG] && s_r.edg[0]) || (fall[SY_TRG] && s_r.edg[1]));
    act_a    = match_a ? s_r.os[1:0] : OUT_KEEP;
    act_b    = match_b ? s_r.os[3:2] : OUT_KEEP;
  end

  // Next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    flg_set  = 3'h0;
    flg_wclr = 3'h0;
    s_nxt.pre = pre_inc;
    s_nxt.sy1 = {start_trigger_pin, ext_clear_pin, ext_count_clock_pin};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.sy3 = s_r.sy2;
    s_nxt.eqa = (s_r.cnt == s_r.cmpa) && !(acc_wr && sel_cmpa);
    s_nxt.eqb = (s_r.cnt == s_r.cmpb) && !(acc_wr && sel_cmpb);
    if (setup_rd) begin
      s_nxt.rdata = {24'h0, rd_mux};
    end
    // Plain register writes
    if (acc_wr && sel_ctl0) begin
      s_nxt.ctl0 = wb;
    end
    if (acc_wr && sel_cmpa) begin
      s_nxt.cmpa = wb;
    end
    if (acc_wr && sel_cmpb) begin
      s_nxt.cmpb = wb;
    end
    if (acc_wr && sel_stat) begin
      s_nxt.os = wb[ST_OS_HI:0];
      flg_wclr[FL_B] = s_r.armed[FL_B] & ~wb[ST_FLG_B];
      flg_wclr[FL_A] = s_r.armed[FL_A] & ~wb[ST_FLG_A];
      flg_wclr[FL_W] = s_r.armed[FL_W] & ~wb[ST_FLG_W];
    end
    if (acc_wr && sel_ctl1) begin
      s_nxt.edg = wb[C1_EDG_HI:C1_EDG_LO];
      s_nxt.te  = wb[C1_TE];
      s_nxt.dps = wb[C1_DPS];
    end
    // Run control: enabling the trigger parks the counter until an edge
    if (!s_nxt.te) begin
      s_nxt.run = ST_RUN;
    end else if (!s_r.te) begin
      s_nxt.run = ST_HALT;
    end else if (trig) begin
      s_nxt.run = ST_RUN;
    end
    if (do_clear && s_r.te) begin
      s_nxt.run = ST_HALT;
    end
    // Counter: software write beats clear, clear beats counting
    if (acc_wr && sel_cnt) begin
      s_nxt.cnt = wb;
    end else if (do_clear) begin
      s_nxt.cnt = RST_CNT;
    end else if (tick && (s_r.run == ST_RUN)) begin
      s_nxt.cnt = s_r.cnt + 8'h01;
      flg_set[FL_W] = (s_r.cnt == CNT_MAX);
    end
    flg_set[FL_A] = match_a;
    flg_set[FL_B] = match_b;
    // A read showing a flag at one arms its clear; a new set wins over a clear
    if (acc_rd && sel_stat) begin
      s_nxt.armed = s_r.armed | s_r.flg;
    end
    s_nxt.armed = s_nxt.armed & ~flg_wclr;
    s_nxt.flg   = (s_r.flg & ~flg_wclr) | flg_set;
    // Wave output with priority toggle, then one, then zero
    if ((act_a == OUT_TGL) || (act_b == OUT_TGL)) begin
      s_nxt.wave = ~s_r.wave;
    end else if ((act_a == OUT_HI) || (act_b == OUT_HI)) begin
      s_nxt.wave = 1'b1;
    end else if ((act_a == OUT_LO) || (act_b == OUT_LO)) begin
      s_nxt.wave = 1'b0;
    end
    // Low-power modes reinitialise the registers and park the counter at zero
    if (low_power_mode) begin
      s_nxt.cnt   = RST_CNT;
      s_nxt.cmpa  = RST_CMP;
      s_nxt.cmpb  = RST_CMP;
      s_nxt.ctl0  = RST_CTL0;
      s_nxt.os    = RST_STAT[ST_OS_HI:0];
      s_nxt.flg   = 3'h0;
      s_nxt.armed = 3'h0;
      s_nxt.edg   = RST_CTL1[C1_EDG_HI:C1_EDG_LO];
      s_nxt.te    = RST_CTL1[C1_TE];
      s_nxt.dps   = RST_CTL1[C1_DPS];
      s_nxt.run   = ST_RUN;
    end
  end

  // State register; async reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r       <= '0;
      s_r.ctl0  <= RST_CTL0;
      s_r.cmpa  <= RST_CMP;
      s_r.cmpb  <= RST_CMP;
      s_r.cnt   <= RST_CNT;
      s_r.os    <= RST_STAT[ST_OS_HI:0];
      s_r.edg   <= RST_CTL1[C1_EDG_HI:C1_EDG_LO];
      s_r.te    <= RST_CTL1[C1_TE];
      s_r.dps   <= RST_CTL1[C1_DPS];
      s_r.run   <= ST_RUN;
      s_r.eqa   <= 1'b0;
      s_r.eqb   <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // ebct_top

// File: pkg/ebct_pkg.sv
package ebct_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned ADDR_W   = 18;
  localparam logic [15:0] IDX_CTL0 = 16'hffb8;
  localparam logic [15:0] IDX_STAT = 16'hffb9;
  localparam logic [15:0] IDX_CMPA = 16'hffba;
  localparam logic [15:0] IDX_CMPB = 16'hffbb;
  localparam logic [15:0] IDX_CNT  = 16'hffbc;
  localparam logic [15:0] IDX_CTL1 = 16'hffbd;

  // Reset values
  localparam logic [7:0] RST_CTL0 = 8'h00;
  localparam logic [7:0] RST_STAT = 8'h10;
  localparam logic [7:0] RST_CMP  = 8'hff;
  localparam logic [7:0] RST_CNT  = 8'h00;
  localparam logic [7:0] RST_CTL1 = 8'he2;
  localparam logic [7:0] CNT_MAX  = 8'hff;

  // Field positions of timer_control_0
  localparam int unsigned C0_IE_B = 7;
  localparam int unsigned C0_IE_A = 6;
  localparam int unsigned C0_IE_W = 5;
  localparam int unsigned C0_CLR_HI = 4;
  localparam int unsigned C0_CLR_LO = 3;
  localparam int unsigned C0_CKS_HI = 2;

  // Field positions of timer_control_status; reserved bits read as one
  localparam int unsigned ST_FLG_B = 7;
  localparam int unsigned ST_FLG_A = 6;
  localparam int unsigned ST_FLG_W = 5;
  localparam int unsigned ST_OS_HI = 3;
  localparam logic [7:0]  ST_FIXED = 8'h10;

  // Field positions of timer_control_1; reserved bits read as one
  localparam int unsigned C1_EDG_HI = 4;
  localparam int unsigned C1_EDG_LO = 3;
  localparam int unsigned C1_TE     = 2;
  localparam int unsigned C1_DPS    = 0;
  localparam logic [7:0]  C1_FIXED  = 8'he2;

  // Counter clear source codes
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A    = 2'h1;
  localparam logic [1:0] CLR_B    = 2'h2;
  localparam logic [1:0] CLR_EXT  = 2'h3;

  // Clock select codes
  localparam logic [2:0] CKS_D4  = 3'h1;
  localparam logic [2:0] CKS_D16 = 3'h2;
  localparam logic [2:0] CKS_D64 = 3'h3;
  localparam logic [2:0] CKS_XR  = 3'h5;
  localparam logic [2:0] CKS_XF  = 3'h6;
  localparam logic [2:0] CKS_XB  = 3'h7;

  // Output actions on a match
  localparam logic [1:0] OUT_KEEP = 2'h0;
  localparam logic [1:0] OUT_LO   = 2'h1;
  localparam logic [1:0] OUT_HI   = 2'h2;
  localparam logic [1:0] OUT_TGL  = 2'h3;

  // Flag vector positions and synchroniser lanes
  localparam int unsigned FL_W = 0;
  localparam int unsigned FL_A = 1;
  localparam int unsigned FL_B = 2;
  localparam int unsigned SY_CLK = 0;
  localparam int unsigned SY_CLR = 1;
  localparam int unsigned SY_TRG = 2;
  localparam int unsigned NSYNC  = 3;
  localparam int unsigned PRE_W  = 7;

  typedef enum logic {ST_RUN = 1'b0, ST_HALT = 1'b1} ebct_run_e;

  typedef struct packed {
    logic [7:0]       ctl0;
    logic [1:0]       edg;
    logic             te;
    logic             dps;
    logic [3:0]       os;
    logic [2:0]       flg;
    logic [2:0]       armed;
    logic [7:0]       cmpa;
    logic [7:0]       cmpb;
    logic [7:0]       cnt;
    logic [PRE_W-1:0] pre;
    ebct_run_e        run;
    logic             eqa;
    logic             eqb;
    logic [NSYNC-1:0] sy1;
    logic [NSYNC-1:0] sy2;
    logic [NSYNC-1:0] sy3;
    logic             wave;
    logic [31:0]      rdata;
  } ebct_state_s;

endpackage

// File: test/ebct_assertions.sv
`timescale 1ns/1ps
module ebct_assertions (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [ebct_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        ext_count_clock_pin,
  input wire logic                        ext_clear_pin,
  input wire logic                        start_trigger_pin,
  input wire logic                        low_power_mode,
  input wire logic                        wave_out_pin,
  input wire logic                        match_a_irq,
  input wire logic                        match_b_irq,
  input wire logic                        wrap_irq
);
  import ebct_pkg::*;
  // Bus decode shared by several checks
  logic acc;
  logic wr_any;
  logic wr_c0;
  logic rd_st;
  assign acc    = psel && penable;
  assign wr_any = acc && pwrite;
  assign wr_c0  = wr_any && (paddr == {IDX_CTL0, 2'h0});
  assign rd_st  = acc && !pwrite && (paddr == {IDX_STAT, 2'h0});
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_always: assert property (pready) else $error("ready low");
  a_misalign_err: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr) else $error("no error");
  a_gate_irq_b: assert property (wr_c0 && !pwdata[7] |=> !match_b_irq) else $error("irq b");
  a_gate_irq_a: assert property (wr_c0 && !pwdata[6] |=> !match_a_irq) else $error("irq a");
  a_gate_irq_wrap: assert property (wr_c0 && !pwdata[5] |=> !wrap_irq) else $error("irq wrap");
  a_flag_sw_clear: assert property ($fell(match_a_irq) |-> $past(wr_any) || $past(low_power_mode))
    else $error("flag fell alone");
  a_low_power_quiet: assert property (low_power_mode |=> !match_a_irq && !match_b_irq && !wrap_irq)
    else $error("irq in low power");
  a_release_quiet: assert property ($rose(presetn) |-> !match_a_irq && !wrap_irq && !wave_out_pin)
    else $error("dirty release");
  a_status_fixed: assert property (rd_st |-> prdata[4] && prdata[31:8] == 24'h0) else $error("status");
  // Main scenarios reached
  c_wrap: cover property ($rose(wrap_irq));
  c_match: cover property ($rose(match_a_irq));
  c_wave: cover property ($rose(wave_out_pin));
endmodule // ebct_assertions

// File: test/ebct_pins.sv
`timescale 1ns/1ps
module ebct_pins (
  input  wire logic pclk,
  output logic      ext_count_clock_pin,
  output logic      ext_clear_pin,
  output logic      start_trigger_pin
);
  logic [2:0] lvl = 3'h0;
  assign {start_trigger_pin, ext_clear_pin, ext_count_clock_pin} = lvl;
  // Pulses held four cycles each way so the synchroniser never misses them
  task automatic pulse(input int lane, input int n);
    repeat (n) begin
      @(posedge pclk);
      lvl[lane] <= 1'b1;
      repeat (4) @(posedge pclk);
      lvl[lane] <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule // ebct_pins

// File: test/ebct_top_test.sv
`timescale 1ns/1ps
module ebct_top_test;
  import ebct_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, low_power_mode, pready, pslverr;
  logic              xclk, xclr, xtrg, wave_out_pin, match_a_irq, match_b_irq, wrap_irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [7:0]        q;
  logic              err_seen;
  int                n_errors = 0;
  int                n_compared = 0;
  logic [15:0]       idx_t [6] = '{IDX_CTL0, IDX_STAT, IDX_CMPA, IDX_CMPB, IDX_CNT, IDX_CTL1};
  logic [7:0]        rst_t [6] = '{8'h00, 8'h10, 8'hff, 8'hff, 8'h00, 8'he2};
  logic [7:0]        ext_t [3] = '{8'h01, 8'h01, 8'h02};

  ebct_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_clock_pin(xclk), .ext_clear_pin(xclr), .start_trigger_pin(xtrg),
    .low_power_mode(low_power_mode), .wave_out_pin(wave_out_pin), .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq), .wrap_irq(wrap_irq));
  ebct_pins pins (.pclk(pclk), .ext_count_clock_pin(xclk), .ext_clear_pin(xclr), .start_trigger_pin(xtrg));

  // Verdict in one place, reached by the tests or the watchdog
  task automatic conclude();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // One APB transfer; an idle edge first so a strobe never rises where it fell
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    err_seen = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d); xfer({i, 2'h0}, 1'b1, d); endtask
  task automatic rd(input logic [15:0] i); xfer({i, 2'h0}, 1'b0, 8'h00); endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    conclude();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = 32'h0; low_power_mode = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(idx_t[i]); chk(q, rst_t[i]);
    end
    xfer({IDX_CTL0, 2'h2}, 1'b0, 8'h00); chk(q, 8'h00);
    chk({7'h0, err_seen}, 8'h01);
    // Stopped counter holds a written value
    wr(IDX_CNT, 8'hfe); rd(IDX_CNT); chk(q, 8'hfe);
    // Wrap through all ones also matches both compares at their reset value
    wr(IDX_CTL0, 8'h25); pins.pulse(SY_CLK, 2);
    rd(IDX_CNT); chk(q, 8'h00);
    chk({7'h0, wrap_irq}, 8'h01);
    chk({7'h0, match_b_irq}, 8'h00);
    wr(IDX_STAT, 8'h00); rd(IDX_STAT); chk(q, 8'hf0);
    wr(IDX_STAT, 8'he0); rd(IDX_STAT); chk(q, 8'hf0);
    wr(IDX_STAT, 8'h00); rd(IDX_STAT); chk(q, 8'h10);
    // Rising, falling and both edges of the external clock
    for (int k = 0; k < 3; k++) begin
      wr(IDX_CTL0, 8'h05 + 8'(k)); wr(IDX_CNT, 8'h00); pins.pulse(SY_CLK, 1);
      rd(IDX_CNT); chk(q, ext_t[k]);
    end
    // Match A clears the count and toggles the wave pin
    wr(IDX_CMPA, 8'h03); wr(IDX_STAT, 8'h03); wr(IDX_CNT, 8'h00); wr(IDX_CTL0, 8'h4d);
    pins.pulse(SY_CLK, 3); rd(IDX_CNT); chk(q, 8'h00);
    chk({7'h0, match_a_irq}, 8'h01);
    chk({7'h0, wave_out_pin}, 8'h01);
    pins.pulse(SY_CLK, 1); rd(IDX_CNT); chk(q, 8'h01);
    // Trigger enable stops counting until a rising trigger edge
    wr(IDX_CTL1, 8'h0c); pins.pulse(SY_CLK, 2); rd(IDX_CNT); chk(q, 8'h01);
    pins.pulse(SY_TRG, 1); pins.pulse(SY_CLK, 3); rd(IDX_CNT); chk(q, 8'h00);
    chk({7'h0, wave_out_pin}, 8'h00);
    // External clear edge
    wr(IDX_CTL1, 8'he2); wr(IDX_CTL0, 8'h1d); wr(IDX_CNT, 8'h20);
    pins.pulse(SY_CLR, 1); rd(IDX_CNT); chk(q, 8'h00);
    pins.pulse(SY_CLK, 1); rd(IDX_CNT); chk(q, 8'h01);
    // Internal divide by four; prescaler phase leaves one count of slack
    wr(IDX_CNT, 8'h00); wr(IDX_CTL0, 8'h01); repeat (40) @(posedge pclk); wr(IDX_CTL0, 8'h00);
    rd(IDX_CNT); chk({7'h0, (q >= 8'h09 && q <= 8'h0b)}, 8'h01);
    // Both matches at once: toggle on B beats drive one on A, so a high pin goes low
    chk({7'h0, wave_out_pin}, 8'h01);
    wr(IDX_CMPA, 8'h02); wr(IDX_CMPB, 8'h02); wr(IDX_STAT, 8'h0e); wr(IDX_CNT, 8'h01); wr(IDX_CTL0, 8'h05);
    pins.pulse(SY_CLK, 1); rd(IDX_CNT); chk(q, 8'h02);
    chk({7'h0, wave_out_pin}, 8'h00);
    // Low-power entry reloads the registers
    wr(IDX_CMPA, 8'h11); wr(IDX_CTL0, 8'hc0);
    @(posedge pclk); low_power_mode <= 1'b1;
    repeat (2) @(posedge pclk); low_power_mode <= 1'b0;
    rd(IDX_CMPA); chk(q, 8'hff);
    rd(IDX_CTL0); chk(q, 8'h00);
    rd(IDX_CNT); chk(q, 8'h00);
    conclude();
  end
endmodule // ebct_top_test

bind ebct_top ebct_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_count_clock_pin(ext_count_clock_pin), .ext_clear_pin(ext_clear_pin),
  .start_trigger_pin(start_trigger_pin), .low_power_mode(low_power_mode), .wave_out_pin(wave_out_pin),
  .match_a_irq(match_a_irq), .match_b_irq(match_b_irq), .wrap_irq(wrap_irq));
